// ### rtl/dac_serial_slave_port_defs.vh
// Constants shared by the two-wire serial slave port of the quad converter.
// Contract
// - Slave only; accepts standard 100k, fast 400k and high-speed 3.4M transfers.
// - Only 7-bit addresses match; 10-bit and general call are ignored.
// - Standard and fast share framing; high-speed is a separate variant.
// - Lines are open-drain: pull low or release, never drive high.
// - Transmitter keeps data stable while clock high; changes only when low.
// - On address match only, device holds data low through ninth clock.
// - Receiver acknowledges each byte on the ninth clock; the port leaves a write byte unacknowledged when its receive FIFO is full.
// - Byte plus acknowledge units repeat without limit until master stops.
// - On stop device releases bus, goes idle, awaits start and match.
// - Converter code is unsigned binary 0..255, output is supply times code/256.
// - Address is fixed 10011 plus two select pins captured after reset.
// - High-speed master code 00001XXX recognised unacknowledged, speeds next transfer.
// - Stop leaves high-speed operation, back to standard or fast.
`ifndef DAC_SERIAL_SLAVE_PORT_DEFS_VH
`define DAC_SERIAL_SLAVE_PORT_DEFS_VH
`define ADDR_FIXED_HI      5'h13
`define HS_CODE_PREFIX     5'h01
`define FILTER_LEN         3
`define FIFO_DEPTH         16
`define FIFO_AW            4
`define DATA_W             8
`define DIR_WRITE          1'b0
`define DIR_READ           1'b1
`define CODE_FULL_SCALE    9'h100
`endif

// ### rtl/stream_fifo.v
// Synchronous FIFO with valid/ready on both sides and registered read data.
`timescale 1ns/1ps
module stream_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire             clock_i,    // System clock.
    input  wire             rst_n_i,    // Synchronous reset, active low.
    input  wire [WIDTH-1:0] in_data_i,  // Write data.
    input  wire             in_valid_i, // Write request.
    output wire             in_ready_o, // Not full.
    output reg  [WIDTH-1:0] out_data_o, // Head word, registered.
    output reg              out_valid_o,// Head word valid.
    input  wire             out_ready_i // Consumer takes head.
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr;
    reg [AW-1:0]    rd_ptr;
    localparam [AW:0] DEPTH_W = DEPTH;

    reg [AW:0]      count;
    wire [AW:0]     held;
    wire            push;
    wire            pop;
    wire            load;

    // The output register is one of the DEPTH slots, so the buffer never holds more than DEPTH.
    assign held       = count + {{AW{1'b0}}, out_valid_o};
    assign in_ready_o = (held != DEPTH_W);
    assign push = in_valid_i && in_ready_o;
    // The output register reloads whenever words are stored and it is empty or being taken.
    assign load = (count != {(AW+1){1'b0}}) && (!out_valid_o || out_ready_i);
    assign pop  = load;

    always @(posedge clock_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    always @(posedge clock_i) begin
        if (!rst_n_i) begin
            wr_ptr      <= {AW{1'b0}};
            rd_ptr      <= {AW{1'b0}};
            count       <= {(AW+1){1'b0}};
            out_valid_o <= 1'b0;
            out_data_o  <= {WIDTH{1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr     <= rd_ptr + 1'b1;
                out_data_o <= mem[rd_ptr];
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
            if (load) begin
                out_valid_o <= 1'b1;
            end else if (out_ready_i) begin
                out_valid_o <= 1'b0;
            end
        end
    end
endmodule

// ### rtl/dac_serial_slave_port.v
// Two-wire serial slave front end with receive FIFO and converter code output.
`timescale 1ns/1ps
`include "dac_serial_slave_port_defs.vh"
module dac_serial_slave_port (
    input  wire        clock_i,               // 100 MHz system clock.
    input  wire        rst_n_i,               // Synchronous reset, active low.
    input  wire        scl_i,                 // Clock line level from pin.
    output reg         scl_o,                 // Clock line drive value, always low.
    output reg         scl_oe_o,              // Clock line enable, never set.
    input  wire        sda_i,                 // Data line level from pin.
    output reg         sda_o,                 // Data line drive value, always low.
    output reg         sda_oe_o,              // High while pulling data low.
    input  wire        device_select_hi_pin_i,// Upper select pin.
    input  wire        device_select_lo_pin_i,// Lower select pin.
    output reg [7:0]   rx_data_o,             // Received write byte.
    output reg         rx_valid_o,            // Received byte valid.
    input  wire        rx_ready_i,            // Consumer takes received byte.
    input  wire [7:0]  tx_data_i,             // Byte returned on reads.
    output reg         tx_taken_o,            // Pulse when tx byte is loaded.
    output reg         busy_o,                // Addressed link active.
    output reg         hs_mode_o,             // High-speed operation active.
    output reg [7:0]   dac_code_o             // Last code byte, unsigned binary.
);
    localparam ST_IDLE  = 3'h0;
    localparam ST_ADDR  = 3'h1;
    localparam ST_AACK  = 3'h2;
    localparam ST_WR    = 3'h3;
    localparam ST_WACK  = 3'h4;
    localparam ST_RD    = 3'h5;
    localparam ST_RACK  = 3'h6;
    localparam ST_WAIT  = 3'h7;

    reg [1:0]  scl_sync;
    reg [1:0]  sda_sync;
    reg [`FILTER_LEN-1:0] scl_hist;
    reg [`FILTER_LEN-1:0] sda_hist;
    reg        scl_f;
    reg        sda_f;
    reg        scl_prev;
    reg        sda_prev;
    reg [2:0]  state;
    reg [3:0]  bitcnt;
    reg [7:0]  shreg;
    reg        dir_read;
    reg        sel_captured;
    reg [1:0]  dev_sel;
    reg [1:0]  sel_sync_hi;
    reg [1:0]  sel_sync_lo;
    reg        fifo_full_ack;
    wire       scl_rise;
    wire       scl_fall;
    wire       start_det;
    wire       stop_det;
    wire       fifo_in_ready;
    wire [7:0] fifo_out_data;
    wire       fifo_out_valid;
    reg        fifo_push;
    reg [7:0]  fifo_push_data;

    // Majority-free stable filter: a line changes only after FILTER_LEN equal samples.
    function stable_val;
        input [`FILTER_LEN-1:0] hist;
        input                   cur;
        begin
            if (&hist) begin
                stable_val = 1'b1;
            end else if (~|hist) begin
                stable_val = 1'b0;
            end else begin
                stable_val = cur;
            end
        end
    endfunction

    always @(posedge clock_i) begin
        if (!rst_n_i) begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
            scl_hist <= {`FILTER_LEN{1'b1}};
            sda_hist <= {`FILTER_LEN{1'b1}};
            scl_f    <= 1'b1;
            sda_f    <= 1'b1;
            scl_prev <= 1'b1;
            sda_prev <= 1'b1;
            // The select synchronisers keep running in reset so the address is settled at release.
            sel_sync_hi <= {sel_sync_hi[0], device_select_hi_pin_i};
            sel_sync_lo <= {sel_sync_lo[0], device_select_lo_pin_i};
        end else begin
            scl_sync <= {scl_sync[0], scl_i};
            sda_sync <= {sda_sync[0], sda_i};
            sel_sync_hi <= {sel_sync_hi[0], device_select_hi_pin_i};
            sel_sync_lo <= {sel_sync_lo[0], device_select_lo_pin_i};
            scl_hist <= {scl_hist[`FILTER_LEN-2:0], scl_sync[1]};
            sda_hist <= {sda_hist[`FILTER_LEN-2:0], sda_sync[1]};
            scl_f    <= stable_val(scl_hist, scl_f);
            sda_f    <= stable_val(sda_hist, sda_f);
            scl_prev <= scl_f;
            sda_prev <= sda_f;
        end
    end

    assign scl_rise  = scl_f && !scl_prev;
    assign scl_fall  = !scl_f && scl_prev;
    assign start_det = scl_f && scl_prev && sda_prev && !sda_f;
    assign stop_det  = scl_f && scl_prev && !sda_prev && sda_f;

    stream_fifo #(
        .WIDTH (`DATA_W),
        .DEPTH (`FIFO_DEPTH),
        .AW    (`FIFO_AW)
    ) u_rx_fifo (
        .clock_i     (clock_i),
        .rst_n_i     (rst_n_i),
        .in_data_i   (fifo_push_data),
        .in_valid_i  (fifo_push),
        .in_ready_o  (fifo_in_ready),
        .out_data_o  (fifo_out_data),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (rx_ready_i && rx_valid_o)
    );

    always @(posedge clock_i) begin
        if (!rst_n_i) begin
            rx_data_o  <= 8'h00;
            rx_valid_o <= 1'b0;
        end else begin
            rx_data_o  <= fifo_out_data;
            rx_valid_o <= fifo_out_valid && !(rx_ready_i && rx_valid_o);
        end
    end

    always @(posedge clock_i) begin
        if (!rst_n_i) begin
            state        <= ST_IDLE;
            bitcnt       <= 4'h0;
            shreg        <= 8'h00;
            dir_read     <= 1'b0;
            sel_captured <= 1'b0;
            dev_sel      <= 2'h0;
            scl_o        <= 1'b0;
            scl_oe_o     <= 1'b0;
            sda_o        <= 1'b0;
            sda_oe_o     <= 1'b0;
            tx_taken_o   <= 1'b0;
            busy_o       <= 1'b0;
            hs_mode_o    <= 1'b0;
            dac_code_o   <= 8'h00;
            fifo_push    <= 1'b0;
            fifo_push_data <= 8'h00;
            fifo_full_ack  <= 1'b0;
        end else begin
            scl_o      <= 1'b0;
            scl_oe_o   <= 1'b0;
            sda_o      <= 1'b0;
            tx_taken_o <= 1'b0;
            fifo_push  <= 1'b0;
            if (!sel_captured) begin
                dev_sel      <= {sel_sync_hi[1], sel_sync_lo[1]};
                sel_captured <= 1'b1;
            end
            if (stop_det) begin
                state     <= ST_IDLE;
                sda_oe_o  <= 1'b0;
                busy_o    <= 1'b0;
                hs_mode_o <= 1'b0;
            end else if (start_det) begin
                state    <= ST_ADDR;
                bitcnt   <= 4'h0;
                sda_oe_o <= 1'b0;
                busy_o   <= 1'b0;
            end else begin
                case (state)
                ST_ADDR: begin
                    if (scl_rise) begin
                        shreg  <= {shreg[6:0], sda_f};
                        bitcnt <= bitcnt + 4'h1;
                    end else if (scl_fall && bitcnt == 4'h8) begin
                        bitcnt <= 4'h0;
                        if (shreg[7:3] == `HS_CODE_PREFIX) begin
                            hs_mode_o <= 1'b1;
                            state     <= ST_WAIT;
                        end else if (shreg[7:3] == `ADDR_FIXED_HI &&
                                     shreg[2:1] == dev_sel) begin
                            dir_read <= (shreg[0] == `DIR_READ);
                            sda_oe_o <= 1'b1;
                            busy_o   <= 1'b1;
                            state    <= ST_AACK;
                        end else begin
                            state <= ST_WAIT;
                        end
                    end
                end
                ST_AACK: begin
                    if (scl_fall) begin
                        bitcnt <= 4'h0;
                        if (dir_read) begin
                            shreg      <= {tx_data_i[6:0], 1'b0};
                            sda_oe_o   <= !tx_data_i[7];
                            tx_taken_o <= 1'b1;
                            state      <= ST_RD;
                        end else begin
                            sda_oe_o <= 1'b0;
                            state    <= ST_WR;
                        end
                    end
                end
                ST_WR: begin
                    if (scl_rise) begin
                        shreg  <= {shreg[6:0], sda_f};
                        bitcnt <= bitcnt + 4'h1;
                    end else if (scl_fall && bitcnt == 4'h8) begin
                        bitcnt <= 4'h0;
                        fifo_full_ack <= !fifo_in_ready;
                        if (fifo_in_ready) begin
                            fifo_push      <= 1'b1;
                            fifo_push_data <= shreg;
                            dac_code_o     <= shreg;
                            sda_oe_o       <= 1'b1;
                        end
                        state <= ST_WACK;
                    end
                end
                ST_WACK: begin
                    if (scl_fall) begin
                        sda_oe_o <= 1'b0;
                        state    <= fifo_full_ack ? ST_WAIT : ST_WR;
                    end
                end
                ST_RD: begin
                    if (scl_fall) begin
                        bitcnt <= bitcnt + 4'h1;
                        if (bitcnt == 4'h7) begin
                            sda_oe_o <= 1'b0;
                            state    <= ST_RACK;
                        end else begin
                            sda_oe_o <= !shreg[7];
                            shreg    <= {shreg[6:0], 1'b0};
                        end
                    end
                end
                ST_RACK: begin
                    if (scl_rise) begin
                        dir_read <= !sda_f;
                    end else if (scl_fall) begin
                        bitcnt <= 4'h0;
                        if (dir_read) begin
                            shreg      <= {tx_data_i[6:0], 1'b0};
                            sda_oe_o   <= !tx_data_i[7];
                            tx_taken_o <= 1'b1;
                            state      <= ST_RD;
                        end else begin
                            state <= ST_WAIT;
                        end
                    end
                end
                default: begin
                    sda_oe_o <= 1'b0;
                end
                endcase
            end
        end
    end
endmodule

// ### test/serial_bus_master.sv
// Behavioural two-wire bus master that drives the serial port from the far side.
`timescale 1ns/1ps
module serial_bus_master #(
    parameter int QUARTER = 8 // System cycles in a quarter of one bit period.
) (
    input  wire logic clock_i, // System clock.
    input  wire logic sda_i,   // Resolved data line level.
    output logic      scl_o,   // Clock line: 0 pulls low, 1 releases.
    output logic      sda_o    // Data line: 0 pulls low, 1 releases.
);
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    task automatic pause(input int n);
        repeat (n) @(posedge clock_i);
    endtask
    task automatic start_cond;
        sda_o <= 1'b1;
        pause(QUARTER);
        scl_o <= 1'b1;
        pause(2 * QUARTER);
        sda_o <= 1'b0;
        pause(2 * QUARTER);
        scl_o <= 1'b0;
        pause(QUARTER);
    endtask
    task automatic stop_cond;
        sda_o <= 1'b0;
        pause(QUARTER);
        scl_o <= 1'b1;
        pause(2 * QUARTER);
        sda_o <= 1'b1;
        pause(4 * QUARTER);
    endtask
    // Data moves only while the clock is low; the line is sampled at the end of the high phase.
    task automatic xfer_bit(input logic b, output logic s);
        sda_o <= b;
        pause(QUARTER);
        scl_o <= 1'b1;
        pause(2 * QUARTER);
        s = sda_i;
        scl_o <= 1'b0;
        pause(QUARTER);
    endtask
    task automatic send_byte(input logic [7:0] b, output logic acked);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            xfer_bit(b[i], s);
        end
        xfer_bit(1'b1, s);
        acked = ~s;
    endtask
    task automatic recv_byte(input logic ack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            xfer_bit(1'b1, s);
            b[i] = s;
        end
        xfer_bit(~ack, s);
    endtask
endmodule

// ### test/dac_serial_slave_port_checker.sv
// Concurrent checks on the pins and stream ports of the serial slave port.
`timescale 1ns/1ps
module dac_serial_slave_port_checker (
    input wire logic       clock_i,    // System clock.
    input wire logic       rst_n_i,    // Synchronous reset, active low.
    input wire logic       scl_i,      // Clock line level.
    input wire logic       sda_i,      // Data line level.
    input wire logic       scl_o,      // Clock drive value.
    input wire logic       scl_oe_o,   // Clock drive enable.
    input wire logic       sda_o,      // Data drive value.
    input wire logic       sda_oe_o,   // Data drive enable.
    input wire logic       busy_o,     // Link active.
    input wire logic       hs_mode_o,  // High-speed active.
    input wire logic [7:0] rx_data_o,  // Received byte.
    input wire logic       rx_valid_o, // Received byte valid.
    input wire logic       rx_ready_i, // Consumer ready.
    input wire logic       tx_taken_o  // Read byte loaded.
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    sequence stop_seen;
        scl_i && $past(scl_i) && $rose(sda_i);
    endsequence
    sequence link_released;
        !busy_o && !sda_oe_o;
    endsequence
    scl_released_a: assert property (!scl_oe_o && !scl_o)
        else $error("clock line driven");
    sda_low_only_a: assert property (sda_oe_o |-> !sda_o)
        else $error("data line driven high");
    data_steady_high_a: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe_o))
        else $error("data drive changed while clock high");
    ack_held_high_a: assert property ($rose(scl_i) && sda_oe_o |=> (sda_oe_o && scl_i)[*6])
        else $error("acknowledge not held through high phase");
    busy_ack_follow_a: assert property ($rose(busy_o) |-> ##[0:40] sda_oe_o)
        else $error("address match without acknowledge");
    oe_needs_link_a: assert property (sda_oe_o && scl_i |-> busy_o)
        else $error("data pulled low without a link");
    stop_drops_link_a: assert property (stop_seen |-> ##[1:12] link_released)
        else $error("link kept after stop");
    stop_ends_hs_a: assert property (stop_seen |-> ##[1:12] !hs_mode_o)
        else $error("high speed kept after stop");
    rx_word_hold_a: assert property (rx_valid_o && !rx_ready_i |=> rx_valid_o && $stable(rx_data_o))
        else $error("received word lost while stalled");
    tx_pulse_single_a: assert property (tx_taken_o |-> busy_o ##1 !tx_taken_o)
        else $error("read load pulse malformed");
endmodule
bind dac_serial_slave_port dac_serial_slave_port_checker u_chk (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .scl_i(scl_i), .sda_i(sda_i), .scl_o(scl_o),
    .scl_oe_o(scl_oe_o), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .busy_o(busy_o),
    .hs_mode_o(hs_mode_o), .rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o),
    .rx_ready_i(rx_ready_i), .tx_taken_o(tx_taken_o));

// ### test/dac_serial_slave_port_tb.sv
// Self-checking testbench for the two-wire serial slave port.
`timescale 1ns/1ps
module dac_serial_slave_port_tb;
    localparam logic [6:0] OWN_ADDR = {5'h13, 2'h2};
    logic       clock_i, rst_n_i, sel_hi, sel_lo, rx_ready_i, scl_m, sda_m;
    logic [7:0] tx_data_i, rx_data_o, dac_code_o;
    logic       scl_o, scl_oe_o, sda_o, sda_oe_o, rx_valid_o, tx_taken_o, busy_o, hs_mode_o;
    int         n_fail;
    int         n_tests;
    wire        scl_w = scl_m & ~(scl_oe_o & ~scl_o);
    wire        sda_w = sda_m & ~(sda_oe_o & ~sda_o);
    dac_serial_slave_port u_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .scl_i(scl_w),
        .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
        .device_select_hi_pin_i(sel_hi), .device_select_lo_pin_i(sel_lo),
        .rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o), .rx_ready_i(rx_ready_i),
        .tx_data_i(tx_data_i), .tx_taken_o(tx_taken_o), .busy_o(busy_o),
        .hs_mode_o(hs_mode_o), .dac_code_o(dac_code_o));
    serial_bus_master host (.clock_i(clock_i), .sda_i(sda_w), .scl_o(scl_m), .sda_o(sda_m));
    task automatic check_bit(input logic got, input logic exp, input string what);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: %s got %b want %b", $time, what, got, exp);
        end
    endtask
    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // The next read byte steps forward each time the port loads one.
    always @(posedge clock_i) begin
        if (rst_n_i !== 1'b1) begin
            tx_data_i <= 8'hA5;
        end else if (tx_taken_o === 1'b1) begin
            tx_data_i <= tx_data_i + 8'h11;
        end
    end
    task automatic t_idle;
        check_bit(scl_oe_o, 1'b0, "clock enable");
        check_bit(sda_oe_o, 1'b0, "data enable");
        check_bit(busy_o, 1'b0, "busy");
        check_byte(dac_code_o, 8'h00, "code after reset");
        $display("test idle done");
    endtask
    task automatic t_refuse;
        logic       a;
        logic [7:0] bad [6] = '{8'h98, 8'h9A, 8'h9F, 8'h00, 8'hF0, 8'h94};
        foreach (bad[i]) begin
            host.start_cond();
            host.send_byte(bad[i], a);
            check_bit(a, 1'b0, "foreign address ack");
            host.send_byte(8'h55, a);
            check_bit(a, 1'b0, "byte after foreign address");
            check_bit(busy_o, 1'b0, "busy on foreign address");
            host.stop_cond();
        end
        $display("test refuse done");
    endtask
    task automatic t_read;
        logic       a;
        logic [7:0] d;
        host.start_cond();
        host.send_byte({OWN_ADDR, 1'b1}, a);
        check_bit(a, 1'b1, "read address ack");
        host.recv_byte(1'b1, d);
        check_byte(d, 8'hA5, "first read byte");
        host.recv_byte(1'b0, d);
        check_byte(d, 8'hB6, "second read byte");
        host.stop_cond();
        check_bit(busy_o, 1'b0, "link after stop");
        $display("test read done");
    endtask
    task automatic t_fill_drain;
        logic a;
        int   got;
        host.start_cond();
        host.send_byte({OWN_ADDR, 1'b0}, a);
        check_bit(a, 1'b1, "write address ack");
        for (int k = 0; k < 16; k++) begin
            host.send_byte(8'(k * 17), a);
            check_bit(a, 1'b1, "data ack");
        end
        check_byte(dac_code_o, 8'hFF, "full scale code");
        host.send_byte(8'h5A, a);
        check_bit(a, 1'b0, "byte into full buffer");
        host.stop_cond();
        check_bit(busy_o, 1'b0, "link after stop");
        rx_ready_i <= 1'b1;
        got = 0;
        for (int c = 0; c < 100; c++) begin
            @(posedge clock_i);
            if (rx_valid_o === 1'b1 && rx_ready_i === 1'b1) begin
                check_byte(rx_data_o, 8'(got * 17), "stream word");
                got++;
            end
        end
        check_byte(8'(got), 8'h10, "word count");
        rx_ready_i <= 1'b0;
        $display("test fill and drain done");
    endtask
    task automatic t_high_speed;
        logic a;
        host.start_cond();
        host.send_byte(8'h09, a);
        check_bit(a, 1'b0, "master code ack");
        check_bit(hs_mode_o, 1'b1, "high speed entered");
        host.start_cond();
        host.send_byte({OWN_ADDR, 1'b0}, a);
        check_bit(a, 1'b1, "address ack at high speed");
        host.send_byte(8'h00, a);
        check_byte(dac_code_o, 8'h00, "zero code");
        host.stop_cond();
        check_bit(hs_mode_o, 1'b0, "high speed left");
        $display("test high speed done");
    endtask
    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end
    initial begin
        #400000;
        n_fail++;
        $display("unexpected at %0t: watchdog expired", $time);
        complete_run();
    end
    initial begin
        n_fail = 0;
        n_tests = 0;
        rst_n_i = 1'b0;
        sel_hi = 1'b1;
        sel_lo = 1'b0;
        rx_ready_i = 1'b0;
        repeat (16) @(posedge clock_i);
        rst_n_i <= 1'b1;
        repeat (10) @(posedge clock_i);
        t_idle();
        t_refuse();
        t_read();
        t_fill_drain();
        t_high_speed();
        complete_run();
    end
endmodule
